// File: logic/pport_defines.vh
// register offsets, field positions, reset values and timing counts for the parallel port
`ifndef PPORT_DEFINES_VH
`define PPORT_DEFINES_VH

// ***************************************
// register map (byte addresses)
// ***************************************
`define PP_MODE_OFS 8'h00
`define PP_ADDR_OFS 8'h04
`define PP_DATA_OFS 8'h08
`define PP_STAT_OFS 8'h0c

// ***************************************
// mode register fields
// ***************************************
`define PP_BUSY_BIT 15
`define PP_IRQ_HI 14
`define PP_IRQ_LO 13
`define PP_STEP_HI 12
`define PP_STEP_LO 11
`define PP_WIDE_BIT 10
`define PP_MODE_HI 9
`define PP_MODE_LO 8
`define PP_SETUP_HI 7
`define PP_SETUP_LO 6
`define PP_STRB_HI 5
`define PP_STRB_LO 2
`define PP_HOLD_HI 1
`define PP_HOLD_LO 0
`define PP_MODE_RST 16'h0000
`define PP_CS_EN_BIT 16

// ***************************************
// encodings
// ***************************************
`define PP_OPM_LEGACY 2'h0
`define PP_OPM_ENH 2'h1
`define PP_OPM_MST2 2'h2
`define PP_OPM_MST1 2'h3
`define PP_IRQ_NONE 2'h0
`define PP_IRQ_EOC 2'h1
`define PP_IRQ_BUF3 2'h2
`define PP_STEP_NONE 2'h0
`define PP_STEP_INC 2'h1
`define PP_STEP_DEC 2'h2
`define PP_STEP_BUF 2'h3

// ***************************************
// timing
// ***************************************
`define PP_CLK_NS 4
`define PP_MIN_WAIT_NS 4
`define PP_MIN_WAIT_CYC ((`PP_MIN_WAIT_NS + `PP_CLK_NS - 1) / `PP_CLK_NS)

`endif

// File: logic/slave_buffers.v
// four-entry slave read/write buffer memory with registered read data
`timescale 1ns/1ps
module slave_buffers #(
   parameter WIDTH = 8
) (
   // clock
   input wire clk,
   input wire ce,
   // write port
   input wire wr_en,
   input wire [1:0] wr_idx,
   input wire [WIDTH-1:0] wr_data,
   // read port
   input wire [1:0] rd_idx,
   output reg [WIDTH-1:0] rd_data
);
   reg [WIDTH-1:0] mem [0:3];

   always @(posedge clk) begin
      if (ce) begin
         if (wr_en) begin
            mem[wr_idx] <= wr_data;
         end
         rd_data <= mem[rd_idx];
      end
   end
endmodule // slave_buffers

// File: logic/parallel_port.v
// parallel master/slave port with mode, wait-state and address-step control
// Behaviour
// - busy flag reads 1 during a master transfer, 0 when idle
// - irq select 01 interrupts at the end of every cycle
// - irq select 10 interrupts on buffer three or slave address 11
// - irq select 00 gives no interrupt; 11 is reserved for software
// - step 01 increments the 16-bit address after each cycle
// - step 10 decrements the 16-bit address after each cycle
// - step 00 leaves the address unchanged
// - step 11 auto-advances slave buffer pointers on host strobes in legacy mode, and the read pointer on data register accesses in either slave mode
// - wide bit picks one 16-bit or one 8-bit transfer per data access
// - mode 11 master drives chip selects, direction, enable, address, data
// - mode 10 master drives chip selects, read, write, address, data
// - mode 01 enhanced slave with strobes, select, two address bits
// - mode 00 legacy slave with strobes, select and eight data lines
// - setup wait of one to four clocks, default one
// - strobe wait zero forces setup and hold to one clock on writes
// - strobe wait zero on reads gives one setup, zero hold
// - top two address bits do not step when used as chip selects
// - upper data byte is driven only in 16-bit mode
//
// Strobed register access and the address map were decided locally.
`include "pport_defines.vh"
`timescale 1ns/1ps
module parallel_port (
   // clock and reset
   input wire clk,
   input wire rst_n,
   input wire ce,
   // register port
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // event output
   output reg irq_q,
   // master side pins
   output reg [1:0] chip_select_lines,
   output reg [13:0] port_address_lines,
   output reg read_strobe,
   output reg write_strobe,
   output reg rw_direction_line,
   output reg enable_strobe,
   // data pins, three signals per bit
   input wire [15:0] port_data_in,
   output reg [15:0] port_data_out,
   output reg [15:0] port_data_oe,
   // slave side pins
   input wire slave_chip_select,
   input wire slave_read_strobe,
   input wire slave_write_strobe,
   input wire [1:0] slave_addr_in
);
   // ***************************************
   // states
   // ***************************************
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_SETUP = 4'h2;
   localparam [3:0] S_STRB = 4'h4;
   localparam [3:0] S_HOLD = 4'h8;

   reg [15:0] mode_q;
   reg cs_en_q;
   reg [15:0] addr_q;
   reg [15:0] wdata_q;
   reg [15:0] rdata_q;
   reg [3:0] state_q;
   reg [3:0] cnt_q;
   reg is_rd_q;
   reg [1:0] rd_ptr_q;
   reg [1:0] wr_ptr_q;
   reg [1:0] s_cs_m;
   reg [1:0] s_rd_m;
   reg [1:0] s_wr_m;
   reg [1:0] s_cs_s;
   reg [1:0] s_rd_s;
   reg [1:0] s_wr_s;
   reg [1:0] s_a_m;
   reg [1:0] s_a_s;
   reg [7:0] s_d_m;
   reg [7:0] s_d_s;
   reg s_rd_prev_q;
   reg s_wr_prev_q;
   wire [7:0] buf_rd_data;

   wire [1:0] opm = mode_q[`PP_MODE_HI:`PP_MODE_LO];
   wire [1:0] irq_select = mode_q[`PP_IRQ_HI:`PP_IRQ_LO];
   wire [1:0] step = mode_q[`PP_STEP_HI:`PP_STEP_LO];
   wire wide = mode_q[`PP_WIDE_BIT];
   wire [1:0] setup_wait_count = mode_q[`PP_SETUP_HI:`PP_SETUP_LO];
   wire [3:0] strobe_wait_count = mode_q[`PP_STRB_HI:`PP_STRB_LO];
   wire [1:0] hold_wait_count = mode_q[`PP_HOLD_HI:`PP_HOLD_LO];
   wire master = opm[1];

   // ***************************************
   // helpers
   // ***************************************
   // next port address; chip-select bits kept out of the step
   function [15:0] step_addr;
      input [15:0] a;
      input [1:0] s;
      input keep_top;
      reg [15:0] n;
      begin
         n = a;
         if (s == `PP_STEP_INC) begin
            n = a + 16'h0001;
         end else if (s == `PP_STEP_DEC) begin
            n = a - 16'h0001;
         end
         if (keep_top) begin
            n[15:14] = a[15:14];
         end
         step_addr = n;
      end
   endfunction

   // ***************************************
   // pin synchronisers
   // ***************************************
   always @(posedge clk) begin
      if (ce) begin
         s_cs_m <= {s_cs_m[0], slave_chip_select};
         s_rd_m <= {s_rd_m[0], slave_read_strobe};
         s_wr_m <= {s_wr_m[0], slave_write_strobe};
         s_a_m <= slave_addr_in;
         s_d_m <= port_data_in[7:0];
         s_cs_s <= {s_cs_s[0], s_cs_m[1]};
         s_rd_s <= {s_rd_s[0], s_rd_m[1]};
         s_wr_s <= {s_wr_s[0], s_wr_m[1]};
         s_a_s <= s_a_m;
         s_d_s <= s_d_m;
      end
   end

   // slave strobe edges from second stage only
   wire s_rd_evt = !master && s_cs_s[1] && s_rd_s[1] && !s_rd_prev_q;
   wire s_wr_evt = !master && s_cs_s[1] && s_wr_s[1] && !s_wr_prev_q;
   wire [1:0] s_idx = (opm == `PP_OPM_ENH) ? s_a_s : (step == `PP_STEP_BUF) ? wr_ptr_q : 2'h0;
   wire [1:0] s_ridx = (opm == `PP_OPM_ENH) ? s_a_s : (step == `PP_STEP_BUF) ? rd_ptr_q : 2'h0;

   // ***************************************
   // register access decode
   // ***************************************
   wire wr_mode = reg_wr && reg_addr == `PP_MODE_OFS;
   wire wr_addr = reg_wr && reg_addr == `PP_ADDR_OFS;
   wire acc_data = (reg_wr || reg_rd) && reg_addr == `PP_DATA_OFS;
   wire idle = state_q == S_IDLE;
   wire start = master && idle && acc_data;

   // zero strobe wait overrides the programmed setup and hold
   wire [3:0] setup_cyc = (strobe_wait_count == 4'h0) ? 4'h1 : {2'h0, setup_wait_count} + 4'h1;
   wire [3:0] hold_cyc = (strobe_wait_count != 4'h0) ? {2'h0, hold_wait_count} + 4'h1 :
                         (is_rd_q ? 4'h0 : 4'h1);
   wire m_done = (state_q == S_HOLD && cnt_q == 4'h1) ||
                 (state_q == S_STRB && cnt_q == 4'h0 && hold_cyc == 4'h0);

   slave_buffers #(
      .WIDTH(8)
   ) u_buf (
      .clk(clk),
      .ce(ce),
      .wr_en(s_wr_evt),
      .wr_idx(s_idx),
      .wr_data(s_d_s),
      .rd_idx(s_ridx),
      .rd_data(buf_rd_data)
   );

   // ***************************************
   // main state
   // ***************************************
   always @(posedge clk) begin
      if (!rst_n) begin
         mode_q <= `PP_MODE_RST;
         cs_en_q <= 1'b0;
         addr_q <= 16'h0000;
         wdata_q <= 16'h0000;
         rdata_q <= 16'h0000;
         state_q <= S_IDLE;
         cnt_q <= 4'h0;
         is_rd_q <= 1'b0;
         rd_ptr_q <= 2'h0;
         wr_ptr_q <= 2'h0;
         s_rd_prev_q <= 1'b0;
         s_wr_prev_q <= 1'b0;
         irq_q <= 1'b0;
         reg_rdata <= 32'h0000_0000;
      end else if (ce) begin
         s_rd_prev_q <= s_rd_s[1];
         s_wr_prev_q <= s_wr_s[1];
         irq_q <= 1'b0;
         reg_rdata <= 32'h0000_0000;
         if (wr_mode) begin
            // busy is status, not writable
            mode_q <= {1'b0, reg_wdata[14:0]};
            cs_en_q <= reg_wdata[`PP_CS_EN_BIT];
         end
         if (wr_addr) begin
            addr_q <= reg_wdata[15:0];
         end
         if (reg_rd) begin
            case (reg_addr)
               `PP_MODE_OFS: reg_rdata <= {15'h0000, cs_en_q, !idle, mode_q[14:0]};
               `PP_ADDR_OFS: reg_rdata <= {16'h0000, addr_q};
               `PP_DATA_OFS: reg_rdata <= master ? {16'h0000, rdata_q} : {24'h000000, buf_rd_data};
               `PP_STAT_OFS: reg_rdata <= {28'h0000000, wr_ptr_q, rd_ptr_q};
               default: reg_rdata <= 32'h0000_0000;
            endcase
         end
         if (acc_data && !master) begin
            rd_ptr_q <= (step == `PP_STEP_BUF) ? rd_ptr_q + 2'h1 : rd_ptr_q;
         end
         // slave events
         if (s_rd_evt || s_wr_evt) begin
            if (step == `PP_STEP_BUF && opm == `PP_OPM_LEGACY) begin
               if (s_wr_evt) begin
                  wr_ptr_q <= wr_ptr_q + 2'h1;
               end
               if (s_rd_evt) begin
                  rd_ptr_q <= rd_ptr_q + 2'h1;
               end
            end
            if (irq_select == `PP_IRQ_EOC) begin
               irq_q <= 1'b1;
            end else if (irq_select == `PP_IRQ_BUF3 && (s_wr_evt ? s_idx : s_ridx) == 2'h3) begin
               irq_q <= 1'b1;
            end
         end
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  state_q <= S_SETUP;
                  cnt_q <= setup_cyc;
                  is_rd_q <= reg_rd;
                  wdata_q <= wide ? reg_wdata[15:0] : {8'h00, reg_wdata[7:0]};
               end
            end
            S_SETUP: begin
               if (cnt_q <= `PP_MIN_WAIT_CYC) begin
                  state_q <= S_STRB;
                  cnt_q <= strobe_wait_count;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            S_STRB: begin
               if (cnt_q == 4'h0) begin
                  if (is_rd_q) begin
                     rdata_q <= wide ? port_data_in : {8'h00, port_data_in[7:0]};
                  end
                  if (hold_cyc == 4'h0) begin
                     state_q <= S_IDLE;
                  end else begin
                     state_q <= S_HOLD;
                     cnt_q <= hold_cyc;
                  end
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            S_HOLD: begin
               if (cnt_q == 4'h1) begin
                  state_q <= S_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: state_q <= S_IDLE;
         endcase
         if (m_done) begin
            addr_q <= step_addr(addr_q, step, cs_en_q);
            if (irq_select == `PP_IRQ_EOC) begin
               irq_q <= 1'b1;
            end
         end
      end
   end

   // ***************************************
   // pin drive, registered
   // ***************************************
   wire strb_now = state_q == S_STRB;
   wire in_xfer = !idle;
   always @(posedge clk) begin
      if (!rst_n) begin
         chip_select_lines <= 2'h0;
         port_address_lines <= 14'h0000;
         read_strobe <= 1'b0;
         write_strobe <= 1'b0;
         rw_direction_line <= 1'b0;
         enable_strobe <= 1'b0;
         port_data_out <= 16'h0000;
         port_data_oe <= 16'h0000;
      end else if (ce) begin
         chip_select_lines <= (in_xfer && cs_en_q) ? addr_q[15:14] : 2'h0;
         port_address_lines <= addr_q[13:0];
         read_strobe <= strb_now && is_rd_q && opm == `PP_OPM_MST2;
         write_strobe <= strb_now && !is_rd_q && opm == `PP_OPM_MST2;
         rw_direction_line <= in_xfer && is_rd_q && opm == `PP_OPM_MST1;
         enable_strobe <= strb_now && opm == `PP_OPM_MST1;
         if (master) begin
            port_data_out <= wdata_q;
            port_data_oe <= (in_xfer && !is_rd_q) ? (wide ? 16'hffff : 16'h00ff) : 16'h0000;
         end else begin
            port_data_out <= {8'h00, buf_rd_data};
            port_data_oe <= (s_cs_s[1] && s_rd_s[1]) ? 16'h00ff : 16'h0000;
         end
      end
   end
endmodule // parallel_port

// File: tb/parallel_port_assertions.sv
// concurrent checks on the parallel port register and master pins
`timescale 1ns/1ps
module parallel_port_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // pins
   input wire logic irq_q,
   input wire logic read_strobe,
   input wire logic write_strobe,
   input wire logic rw_direction_line,
   input wire logic enable_strobe,
   input wire logic [15:0] port_data_oe
);
   logic [15:0] mode_q;
   logic [4:0] hi_q;
   wire strb = read_strobe | write_strobe | enable_strobe;
   wire [1:0] sel = mode_q[14:13];
   wire [1:0] opm = mode_q[9:8];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // shadow of the mode register; software only rewrites it while idle
   always @(posedge clk) begin
      if (!rst_n) begin
         mode_q <= 16'h0000;
         hi_q <= 5'h00;
      end else begin
         if (ce && reg_wr && reg_addr == 8'h00) begin
            mode_q <= reg_wdata[15:0];
         end
         hi_q <= strb ? hi_q + 5'h01 : 5'h00;
      end
   end
   sequence s_strobe_end;
      strb ##1 !strb;
   endsequence
   a_strobe_width: assert property (s_strobe_end |-> hi_q == {1'b0, mode_q[5:2]} + 5'h01)
      else $error("strobe width differs from strobe wait");
   a_strobe_excl: assert property (!(read_strobe && write_strobe))
      else $error("read and write strobes together");
   a_rdwr_mode2: assert property ((read_strobe || write_strobe) |-> opm == 2'h2)
      else $error("separate strobes outside mode 10");
   a_enable_mode1: assert property ((enable_strobe || rw_direction_line) |-> opm == 2'h3)
      else $error("enable or direction outside mode 11");
   a_upper_wide: assert property ((|port_data_oe[15:8]) |-> mode_q[10])
      else $error("upper byte driven in narrow mode");
   a_irq_none: assert property (sel == 2'h0 |-> !irq_q)
      else $error("interrupt with select 00");
   a_irq_reserved: assert property (sel == 2'h3 |-> !irq_q)
      else $error("interrupt with reserved select");
   a_irq_end_cycle: assert property (s_strobe_end ##0 (sel == 2'h1) |-> ##[0:8] irq_q)
      else $error("no interrupt after cycle end");
   a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   a_mode_readback: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[14:0] == mode_q[14:0])
      else $error("mode register readback differs");
endmodule // parallel_port_checker

bind parallel_port parallel_port_checker chk_u (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_q(irq_q),
   .read_strobe(read_strobe), .write_strobe(write_strobe), .rw_direction_line(rw_direction_line),
   .enable_strobe(enable_strobe), .port_data_oe(port_data_oe));

// File: tb/ext_memory.sv
// behavioural external memory on the master side of the port
`timescale 1ns/1ps
module ext_memory (
   // clock
   input wire logic clk,
   // master pins
   input wire logic [13:0] port_address_lines,
   input wire logic read_strobe,
   input wire logic write_strobe,
   input wire logic rw_direction_line,
   input wire logic enable_strobe,
   input wire logic [15:0] port_data_out,
   input wire logic [15:0] port_data_oe,
   output logic [15:0] port_data_in,
   output logic [15:0] last_wr = 16'h0000
);
   logic [15:0] idle_q = 16'h0000;
   wire rd_act = read_strobe | rw_direction_line;
   wire wr_act = write_strobe | (enable_strobe & !rw_direction_line);
   // released bus shows a changing pattern so stale data never passes
   assign port_data_in = rd_act ? {port_address_lines[7:0], ~port_address_lines[7:0]} : idle_q;
   always @(posedge clk) begin
      idle_q <= ~idle_q ^ 16'h0001;
      if (wr_act) begin
         last_wr <= port_data_out & port_data_oe;
      end
   end
endmodule // ext_memory

// File: tb/parallel_port_tb_top.sv
// self-checking bench: register tasks and master transfers
`timescale 1ns/1ps
module parallel_port_tb_top;
   logic clk;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] d;
   wire [31:0] reg_rdata;
   wire irq_q, rd_s, wr_s, rw_w, en_w;
   wire [13:0] addr_w;
   wire [15:0] din, dout, doe, last_wr;
   wire [1:0] cs_w;
   logic [1:0] cs_seen = 2'h0;
   logic scs, srd, swr;
   logic [1:0] sa;
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   int irqs = 0;
   parallel_port dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_q(irq_q), .chip_select_lines(cs_w),
      .port_address_lines(addr_w), .read_strobe(rd_s), .write_strobe(wr_s), .rw_direction_line(rw_w),
      .enable_strobe(en_w), .port_data_in(din), .port_data_out(dout), .port_data_oe(doe),
      .slave_chip_select(scs), .slave_read_strobe(srd), .slave_write_strobe(swr), .slave_addr_in(sa));
   ext_memory mem_u (.clk(clk), .port_address_lines(addr_w), .read_strobe(rd_s), .write_strobe(wr_s),
      .rw_direction_line(rw_w), .enable_strobe(en_w), .port_data_out(dout), .port_data_oe(doe),
      .port_data_in(din), .last_wr(last_wr));
   // ***************************************
   // tasks
   // ***************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // host write strobe held long enough to pass the pin synchronisers
   task automatic host_wr(input logic [1:0] a);
      @(posedge clk);
      sa <= a;
      scs <= 1'b1;
      swr <= 1'b1;
      repeat (4) @(posedge clk);
      swr <= 1'b0;
      scs <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // polls busy with a bound so a stuck flag ends as a mismatch
   task automatic idle();
      d = 32'h8000;
      for (int i = 0; i < 40 && d[15] !== 1'b0; i++)
         rd(8'h00);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ***************************************
   // clock, timeout, sequence
   // ***************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (irq_q === 1'b1)
         irqs++;
      if (wr_s === 1'b1)
         cs_seen <= cs_w;
      if (cycles == 3000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      scs = 1'b0;
      srd = 1'b0;
      swr = 1'b0;
      sa = 2'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00);
      chk(d, 32'h0);
      rd(8'h10);
      chk(d, 32'h0);
      // wide write, mode 10, setup 2, strobe wait 2, hold 2
      wr(8'h04, 32'h1233);
      wr(8'h00, 32'h2e49);
      wr(8'h08, 32'ha55a);
      rd(8'h00);
      chk({31'h0, d[15]}, 32'h1);
      idle();
      chk({31'h0, d[15]}, 32'h0);
      chk({16'h0, last_wr}, 32'ha55a);
      rd(8'h04);
      chk(d, 32'h1234);
      chk(irqs, 32'h1);
      // narrow reads in mode 11 with no waits, decrementing
      wr(8'h00, 32'h1300);
      rd(8'h08);
      idle();
      rd(8'h04);
      chk(d, 32'h1233);
      rd(8'h08);
      chk(d & 32'hff, 32'hcb);
      idle();
      chk(irqs, 32'h1);
      // top address bits as chip selects, reserved interrupt select
      wr(8'h04, 32'hbfff);
      wr(8'h00, 32'h16a00);
      wr(8'h08, 32'h3377);
      idle();
      rd(8'h04);
      chk(d, 32'h8000);
      chk(irqs, 32'h1);
      chk({16'h0, last_wr}, 32'h0077);
      chk({30'h0, cs_seen}, 32'h2);
      // no address step
      wr(8'h00, 32'h2600);
      wr(8'h08, 32'h1111);
      idle();
      rd(8'h04);
      chk(d, 32'h8000);
      chk(irqs, 32'h2);
      // enhanced slave, interrupt only on host address 11
      wr(8'h00, 32'h4100);
      host_wr(2'h1);
      chk(irqs, 32'h2);
      host_wr(2'h3);
      chk(irqs, 32'h3);
      conclude();
   end
endmodule // parallel_port_tb_top
